// ==== vshi_asserts.sv ====
// port assertions for the host interface
`timescale 1ns/100ps
module vshi_asserts import vshi_pkg::*; #(
   parameter int SEG_W = 16
)(
   // system
   input wire logic mclk,
   input wire logic rst_b,
   // pins
   input wire logic spi_cs_n,
   input wire logic spi_dout_oe,
   input wire logic reset_pin_n,
   input wire logic segment_end_warning_n,
   input wire logic irq_n_out,
   input wire logic irq_n_oe,
   input wire logic busy_n,
   input wire logic squelch_active_n,
   // core side
   input wire logic op_start,
   input wire logic end_of_message,
   input wire logic overflow,
   input wire logic squelch_engaged,
   input wire logic sample_tick,
   input wire logic [SEG_W-1:0] segment_index
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   property p_cs_off; spi_cs_n [*6] |-> !spi_dout_oe; endproperty
   a_cs_off: assert property (p_cs_off) else $error("output driven while deselected");
   property p_cs_on; !spi_cs_n [*6] |-> spi_dout_oe; endproperty
   a_cs_on: assert property (p_cs_on) else $error("output idle while selected");
   property p_busy; op_start && busy_n |-> ##2 !busy_n; endproperty
   a_busy: assert property (p_busy) else $error("busy did not fall");
   property p_sql; squelch_engaged [*2] |-> !squelch_active_n; endproperty
   a_sql: assert property (p_sql) else $error("squelch flag missing");
   property p_irq; end_of_message || overflow |-> ##2 irq_n_oe; endproperty
   a_irq: assert property (p_irq) else $error("interrupt not pulled");
   property p_od; irq_n_oe |-> !irq_n_out; endproperty
   a_od: assert property (p_od) else $error("open drain drives high");
   property p_wfall; $fell(segment_end_warning_n) |-> $past(sample_tick) && !busy_n; endproperty
   a_wfall: assert property (p_wfall) else $error("warning fell off a tick");
   property p_wrise;
      $rose(segment_end_warning_n) && $past(sample_tick) && reset_pin_n
         |-> segment_index != $past(segment_index);
   endproperty
   a_wrise: assert property (p_wrise) else $error("segment not advanced");
   property p_rpin;
      !reset_pin_n [*5] |-> busy_n && segment_end_warning_n && segment_index == '0;
   endproperty
   a_rpin: assert property (p_rpin) else $error("reset pin did not clear");
endmodule : vshi_asserts
bind vshi_top vshi_asserts #(.SEG_W(SEG_W)) u_vshi_asserts (.mclk, .rst_b, .spi_cs_n,
   .spi_dout_oe, .reset_pin_n, .segment_end_warning_n, .irq_n_out, .irq_n_oe, .busy_n,
   .squelch_active_n, .op_start, .end_of_message, .overflow, .squelch_engaged,
   .sample_tick, .segment_index);

// ==== vshi_host.sv ====
// spi master model on the host pins
`timescale 1ns/100ps
module vshi_host (
   // clock
   input wire logic mclk,
   // spi pins
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   task automatic half;
      repeat (8) @(posedge mclk);
      #1;
   endtask : half
   // byte framed by chip select low
   task automatic xfer(input logic [7:0] b, output logic [7:0] r);
      cs_n = 1'b0;
      half();
      for (int i = 7; i >= 0; i--) begin
         din = b[i];
         half();
         sclk = 1'b1;
         r[i] = dout;
         half();
         sclk = 1'b0;
      end
      half();
      cs_n = 1'b1;
   endtask : xfer
   // clock and data wander while deselected
   task automatic junk;
      repeat (8) begin
         sclk = ~sclk;
         din = ~din;
         half();
      end
   endtask : junk
endmodule : vshi_host

// ==== vshi_pkg.sv ====
// constants shared by the voice store host interface
package vshi_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int INT_SAMPLE_HZ = 6400;
   localparam int INT_DIV_CYCLES = CLK_HZ / INT_SAMPLE_HZ;
   localparam int EXT_TIMEOUT_US = 1000;
   localparam int EXT_TIMEOUT_CYCLES = (CLK_HZ / 1_000_000) * EXT_TIMEOUT_US;
   localparam int SPI_BITS = 8;
   localparam int SYNC_W = 5;
   localparam int SYNC_CS = 0;
   localparam int SYNC_SCLK = 1;
   localparam int SYNC_DIN = 2;
   localparam int SYNC_EXT = 3;
   localparam int SYNC_RST = 4;
   localparam logic [4:0] SYNC_RST_VAL = 5'h11;
   localparam logic WARN_RST = 1'b1;
   localparam logic BUSY_RST = 1'b1;
   localparam logic SQL_RST = 1'b1;
   localparam logic IRQ_RST = 1'b1;
   typedef enum logic [0:0] {
      OP_IDLE = 1'b0,
      OP_RUN = 1'b1
   } vshi_op_e;
endpackage : vshi_pkg

// ==== vshi_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module vshi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         meta_reg <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : vshi_sync

// ==== vshi_top.sv ====
// host pin interface of the voice store device
`timescale 1ns/100ps
module vshi_top import vshi_pkg::*; #(
   parameter int INT_DIV = INT_DIV_CYCLES,
   parameter int EXT_TIMEOUT = EXT_TIMEOUT_CYCLES,
   parameter int SEG_W = 16
)(
   // system
   input wire logic mclk,
   input wire logic rst_b,
   // host spi pins
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic serial_data_in,
   output logic spi_dout,
   output logic spi_dout_oe,
   // device pins
   input wire logic reset_pin_n,
   input wire logic external_sample_clock,
   output logic segment_end_warning_n,
   output logic irq_n_out,
   output logic irq_n_oe,
   output logic busy_n,
   output logic squelch_active_n,
   // core side spi data
   input wire logic [SPI_BITS-1:0] tx_byte,
   output logic [SPI_BITS-1:0] cmd_byte,
   output logic cmd_valid,
   // core side operation
   input wire logic op_start,
   input wire logic op_stop,
   input wire logic [SEG_W-1:0] segment_length,
   input wire logic end_of_message,
   input wire logic overflow,
   input wire logic irq_clear,
   input wire logic squelch_engaged,
   // sample clock and segment index
   output logic sample_tick,
   output logic sample_src_ext,
   output logic [SEG_W-1:0] segment_index
);
   localparam int DIV_W = $clog2(INT_DIV + 1);
   localparam int TMO_W = $clog2(EXT_TIMEOUT + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_DIV - 1);
   localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(EXT_TIMEOUT - 1);
   localparam logic [2:0] BIT_LAST = 3'(SPI_BITS - 1);

   logic [SYNC_W-1:0] pins_raw, pins_sync;
   logic s_cs_n, s_sclk, s_din, s_ext, s_rst_n;
   logic sclk_d_reg, ext_d_reg, sclk_rise, sclk_fall, ext_rise, dev_clr;
   logic [2:0] bit_cnt_reg;
   logic [SPI_BITS-1:0] rx_sh_reg, tx_sh_reg;
   logic rx_done_reg;
   logic [SPI_BITS-1:0] rx_byte_reg;
   logic [DIV_W-1:0] div_cnt_reg;
   logic [TMO_W-1:0] tmo_cnt_reg;
   logic ext_present_reg;
   vshi_op_e op_reg;
   logic [SEG_W-1:0] seg_cnt_reg, seg_cnt_next;
   logic pend_reg, can_issue, irq_pend_reg;
   logic [SPI_BITS-1:0] pend_byte_reg;

   assign pins_raw = {reset_pin_n, external_sample_clock, serial_data_in, spi_sclk, spi_cs_n};

   vshi_sync #(
      .W(SYNC_W),
      .RST_VAL(SYNC_RST_VAL)
   ) u_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .d(pins_raw),
      .q(pins_sync)
   );

   assign s_cs_n = pins_sync[SYNC_CS];
   assign s_sclk = pins_sync[SYNC_SCLK];
   assign s_din = pins_sync[SYNC_DIN];
   assign s_ext = pins_sync[SYNC_EXT];
   assign s_rst_n = pins_sync[SYNC_RST];
   assign dev_clr = !rst_b || !s_rst_n;
   assign sclk_rise = s_sclk && !sclk_d_reg;
   assign sclk_fall = !s_sclk && sclk_d_reg;
   assign ext_rise = s_ext && !ext_d_reg;
   assign seg_cnt_next = seg_cnt_reg + SEG_W'(1);
   assign can_issue = (op_reg == OP_IDLE) || !segment_end_warning_n;

   // edge detect history
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sclk_d_reg <= 1'b0;
         ext_d_reg <= 1'b0;
      end else begin
         sclk_d_reg <= s_sclk;
         ext_d_reg <= s_ext;
      end
   end

   // spi receive shifter
   always_ff @(posedge mclk) begin
      rx_done_reg <= 1'b0;
      if (dev_clr) begin
         bit_cnt_reg <= 3'h0;
         rx_sh_reg <= '0;
         rx_byte_reg <= '0;
      end else if (s_cs_n) begin
         bit_cnt_reg <= 3'h0;
      end else if (sclk_rise) begin
         rx_sh_reg <= {rx_sh_reg[SPI_BITS-2:0], s_din};
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == BIT_LAST) begin
            rx_byte_reg <= {rx_sh_reg[SPI_BITS-2:0], s_din};
            rx_done_reg <= 1'b1;
         end
      end
   end

   // spi transmit shifter
   always_ff @(posedge mclk) begin
      if (dev_clr) begin
         tx_sh_reg <= '0;
         spi_dout <= 1'b0;
         spi_dout_oe <= 1'b0;
      end else begin
         spi_dout_oe <= !s_cs_n;
         if (s_cs_n) begin
            tx_sh_reg <= tx_byte;
            spi_dout <= tx_byte[SPI_BITS-1];
         end else if (sclk_fall) begin
            if (bit_cnt_reg == 3'h0) begin
               tx_sh_reg <= tx_byte;
               spi_dout <= tx_byte[SPI_BITS-1];
            end else begin
               tx_sh_reg <= {tx_sh_reg[SPI_BITS-2:0], 1'b0};
               spi_dout <= tx_sh_reg[SPI_BITS-2];
            end
         end
      end
   end

   // command hand-off and queue
   always_ff @(posedge mclk) begin
      cmd_valid <= 1'b0;
      if (dev_clr) begin
         pend_reg <= 1'b0;
         pend_byte_reg <= '0;
         cmd_byte <= '0;
      end else if (pend_reg && can_issue) begin
         cmd_byte <= pend_byte_reg;
         cmd_valid <= 1'b1;
         pend_reg <= rx_done_reg;
         if (rx_done_reg) begin
            pend_byte_reg <= rx_byte_reg;
         end
      end else if (rx_done_reg) begin
         if (can_issue && !pend_reg) begin
            cmd_byte <= rx_byte_reg;
            cmd_valid <= 1'b1;
         end else begin
            pend_reg <= 1'b1;
            pend_byte_reg <= rx_byte_reg;
         end
      end
   end

   // internal oscillator divider
   always_ff @(posedge mclk) begin
      if (dev_clr) begin
         div_cnt_reg <= '0;
      end else if (div_cnt_reg == DIV_LAST) begin
         div_cnt_reg <= '0;
      end else begin
         div_cnt_reg <= div_cnt_reg + DIV_W'(1);
      end
   end

   // external clock presence detect
   always_ff @(posedge mclk) begin
      if (dev_clr) begin
         tmo_cnt_reg <= '0;
         ext_present_reg <= 1'b0;
      end else if (ext_rise) begin
         tmo_cnt_reg <= '0;
         ext_present_reg <= 1'b1;
      end else if (tmo_cnt_reg == TMO_LAST) begin
         ext_present_reg <= 1'b0;
      end else begin
         tmo_cnt_reg <= tmo_cnt_reg + TMO_W'(1);
      end
   end

   // sample tick source mux
   always_ff @(posedge mclk) begin
      if (dev_clr) begin
         sample_tick <= 1'b0;
         sample_src_ext <= 1'b0;
      end else begin
         sample_tick <= ext_present_reg ? ext_rise : (div_cnt_reg == DIV_LAST);
         sample_src_ext <= ext_present_reg;
      end
   end

   // operation and segment tracking
   always_ff @(posedge mclk) begin
      if (dev_clr) begin
         op_reg <= OP_IDLE;
         seg_cnt_reg <= '0;
         segment_index <= '0;
         segment_end_warning_n <= WARN_RST;
      end else begin
         case (op_reg)
            OP_IDLE: begin
               if (op_start) begin
                  op_reg <= OP_RUN;
                  seg_cnt_reg <= '0;
                  segment_end_warning_n <= 1'b1;
               end
            end
            OP_RUN: begin
               if (op_stop) begin
                  op_reg <= OP_IDLE;
                  segment_end_warning_n <= 1'b1;
               end else if (sample_tick) begin
                  if (seg_cnt_next >= segment_length) begin
                     seg_cnt_reg <= '0;
                     segment_index <= segment_index + SEG_W'(1);
                     segment_end_warning_n <= 1'b1;
                  end else begin
                     seg_cnt_reg <= seg_cnt_next;
                     if (seg_cnt_next == (segment_length >> 1)) begin
                        segment_end_warning_n <= 1'b0;
                     end
                  end
               end
            end
            default: begin
               op_reg <= OP_IDLE;
            end
         endcase
      end
   end

   // busy and squelch outputs
   always_ff @(posedge mclk) begin
      if (dev_clr) begin
         busy_n <= BUSY_RST;
         squelch_active_n <= SQL_RST;
      end else begin
         busy_n <= (op_reg != OP_RUN);
         squelch_active_n <= !squelch_engaged;
      end
   end

   // open-drain interrupt
   always_ff @(posedge mclk) begin
      if (dev_clr) begin
         irq_pend_reg <= 1'b0;
         irq_n_out <= IRQ_RST;
         irq_n_oe <= 1'b0;
      end else begin
         if (end_of_message || overflow) begin
            irq_pend_reg <= 1'b1;
         end else if (irq_clear) begin
            irq_pend_reg <= 1'b0;
         end
         irq_n_out <= !irq_pend_reg;
         irq_n_oe <= irq_pend_reg;
      end
   end
endmodule : vshi_top

// ==== vshi_top_tb.sv ====
// self-checking bench for the host interface
`timescale 1ns/100ps
module vshi_top_tb import vshi_pkg::*; ;
   localparam int LEN = 8;
   logic mclk, rst_b, rpin_n, ext, eom, ovf, iclr, sql_in, start, stop, cs_n, sclk, din, dout;
   logic oe, dlast, warn_n, wprev, irq_o, irq_oe, busy_n, sql_n, cvalid, tick, src_ext;
   logic [7:0] tx_byte, cmd_byte, rx;
   logic [15:0] seg_idx;
   logic [2:0] okh;
   logic [31:0] lf = 32'hdf21;
   logic [7:0] exp_q[$];
   int n_mismatch = 0, total_checks = 0, ticks = 0, t0 = 0, nt = 0;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("mismatch at %0t: got %0h want %0h", $time, seen, want);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (oe) dlast <= dout;
   vshi_host u_vshi_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout(oe ? dout : ~dlast));
   vshi_top #(.INT_DIV(16), .EXT_TIMEOUT(64), .SEG_W(16)) u_vshi_top (.mclk(mclk),
      .rst_b(rst_b), .spi_cs_n(cs_n), .spi_sclk(sclk), .serial_data_in(din), .spi_dout(dout),
      .spi_dout_oe(oe), .reset_pin_n(rpin_n), .external_sample_clock(ext),
      .segment_end_warning_n(warn_n), .irq_n_out(irq_o), .irq_n_oe(irq_oe), .busy_n(busy_n),
      .squelch_active_n(sql_n), .tx_byte(tx_byte), .cmd_byte(cmd_byte), .cmd_valid(cvalid),
      .op_start(start), .op_stop(stop), .segment_length(16'(LEN)), .end_of_message(eom),
      .overflow(ovf), .irq_clear(iclr), .squelch_engaged(sql_in), .sample_tick(tick),
      .sample_src_ext(src_ext), .segment_index(seg_idx));
   always @(posedge mclk) begin
      okh <= {okh[1:0], busy_n | ~warn_n};
      wprev <= warn_n;
      if (tick) ticks++;
      if (cvalid) begin
         check(cmd_byte, exp_q.pop_front());
         check(|{okh, busy_n | ~warn_n}, 1);
      end
      if (rst_b && rpin_n && warn_n !== wprev && !busy_n)
         check((ticks - t0) % LEN, warn_n ? 0 : LEN / 2);
   end
   initial begin
      {rst_b, ext, eom, ovf, iclr, sql_in, start, stop, tx_byte} = '0;
      rpin_n = 1'b1;
      cyc(6);
      rst_b = 1'b1;
      cyc(4);
      check(src_ext, 0);
      nt = ticks;
      cyc(160);
      check(ticks - nt, 10);
      for (int k = 0; k < 3; k++) begin
         lf = lfsr(lf);
         tx_byte = lf[7:0];
         exp_q.push_back(lf[15:8]);
         u_vshi_host.junk();
         u_vshi_host.xfer(lf[15:8], rx);
         check(rx, tx_byte);
      end
      @(posedge mclk iff tick);
      #1;
      t0 = ticks;
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      lf = lfsr(lf);
      exp_q.push_back(lf[7:0]);
      u_vshi_host.xfer(lf[7:0], rx);
      repeat (2) @(posedge warn_n);
      cyc(2);
      check(seg_idx, (ticks - t0) / LEN);
      check(exp_q.size(), 0);
      sql_in = 1'b1;
      cyc(3);
      check(sql_n, 0);
      sql_in = 1'b0;
      eom = 1'b1;
      cyc(1);
      eom = 1'b0;
      cyc(3);
      check({irq_oe, irq_o}, 2'b10);
      iclr = 1'b1;
      cyc(1);
      {iclr, ovf} = 2'b01;
      cyc(1);
      ovf = 1'b0;
      check({irq_oe, irq_o}, 2'b01);
      cyc(3);
      check({irq_oe, irq_o}, 2'b10);
      {iclr, ovf} = 2'b11;
      cyc(1);
      {iclr, ovf} = 2'b00;
      cyc(2);
      check({irq_oe, irq_o}, 2'b10);
      rpin_n = 1'b0;
      cyc(6);
      check({busy_n, seg_idx}, 17'h10000);
      rpin_n = 1'b1;
      cyc(6);
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      cyc(4);
      stop = 1'b1;
      cyc(1);
      stop = 1'b0;
      cyc(4);
      check(busy_n, 1);
      fork
         repeat (60) #80 ext = ~ext;
         begin
            cyc(200);
            check(src_ext, 1);
            nt = ticks;
            cyc(160);
            check(ticks - nt, 10);
         end
      join
      cyc(100);
      check(src_ext, 0);
      give_verdict();
   end
   initial begin
      #300us;
      n_mismatch++;
      give_verdict();
   end
endmodule : vshi_top_tb
